// *** bfcc_core.sv ***
// command logic for identity, clear and format control on the sensor bus
`default_nettype none
module bfcc_core
    import bfcc_pkg::*;
#(
    parameter logic [3:0] SILICON_VERSION = 4'h2 // arbitrary value
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic clk_en,
    // decoded command from the bus receiver
    input wire logic cmd_valid,
    input wire bfcc_pkg::bfcc_cmd_s cmd,
    input wire logic msg_start,
    // address assigned by the initialization command
    input wire logic [3:0] assigned_address,
    // fuse parity check at power-up
    input wire logic fuse_check_done,
    input wire logic fuse_parity_calc,
    input wire logic fuse_parity_stored,
    // response to the bus transmitter
    output logic rsp_valid,
    output logic [15:0] rsp_word,
    // effects on the rest of the device
    output logic clear_pulse,
    output logic bus_switch_open,
    output logic fuse_parity_error,
    // active framing and crc format
    output bfcc_pkg::bfcc_fmt_s fmt_active,
    output logic [3:0] crc_preload,
    output logic [4:0] crc_poly
);
    import bfcc_pkg::*;
    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    wire logic is_long = (cmd.kind == WORD_LONG);
    wire logic addr_zero = (cmd.addr == ADDR_GLOBAL);
    wire logic addr_own = (cmd.addr == assigned_address);
    wire logic go = clk_en & cmd_valid;
    wire logic clr_hit = go & (cmd.cmd == CMD_CLEAR) & (addr_own | addr_zero);
    wire logic fmt_hit = go & is_long & (cmd.cmd == CMD_FMT) & (addr_own | addr_zero);
    wire logic fmt_rsp = fmt_hit & ~addr_zero;
    wire logic id_rsp = go & is_long & (cmd.cmd == CMD_ID) & addr_own & ~addr_zero;
    wire logic wr_flag = cmd.data[FB_WR];
    wire logic [2:0] ptr = cmd.data[FB_PTR_HI:FB_PTR_LO];
    wire logic [3:0] wdat = cmd.data[FB_DAT_HI:0];
    wire logic wr = fmt_hit & wr_flag;
    // ------------------------------------------------------------
    // format registers
    // ------------------------------------------------------------
    logic [3:0] taps_q, seed_q, len_q, sel_q;
    logic fuse_err_q, sw_open_q;
    wire logic enh = (sel_q == SEL_ON);
    wire logic lock = enh;
    wire logic wr_taps = wr & (ptr == LOC_TAPS) & ~lock;
    wire logic wr_seed = wr & (ptr == LOC_SEED) & ~lock;
    wire logic len_ok = (wdat == LEN_8) | (wdat == LEN_10);
    wire logic wr_len = wr & (ptr == LOC_LEN) & ~lock & len_ok;
    // selection only flips on a full 1111 or 0000 write
    wire logic sel_on = wr & (ptr == LOC_SEL) & ~enh & (wdat == SEL_ON);
    wire logic sel_off = wr & (ptr == LOC_SEL) & enh & (wdat == SEL_OFF);
    wire logic rsvd = ~((ptr == LOC_TAPS) | (ptr == LOC_SEED) | (ptr == LOC_LEN)
        | (ptr == LOC_SEL));
    logic [3:0] rd_val;
    always_comb begin
        unique case (ptr)
            LOC_TAPS: rd_val = taps_q;
            LOC_SEED: rd_val = seed_q;
            LOC_LEN: rd_val = len_q;
            LOC_SEL: rd_val = sel_q;
            default: rd_val = NIBBLE_ZERO;
        endcase
    end
    // write echoes written data, zero for reserved; read returns contents
    wire logic [3:0] echo = wr_flag ? (rsvd ? NIBBLE_ZERO : wdat) : rd_val;
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            taps_q <= RST_TAPS;
            seed_q <= RST_SEED;
            len_q <= RST_LEN;
            sel_q <= RST_SEL;
        end else if (clr_hit) begin
            taps_q <= RST_TAPS;
            seed_q <= RST_SEED;
            len_q <= RST_LEN;
            sel_q <= RST_SEL;
        end else if (clk_en) begin
            if (wr_taps) taps_q <= wdat;
            if (wr_seed) seed_q <= wdat;
            if (wr_len) len_q <= wdat;
            if (sel_on) sel_q <= SEL_ON;
            if (sel_off) sel_q <= SEL_OFF;
        end
    end
    // ------------------------------------------------------------
    // fuse parity and bus switch
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            fuse_err_q <= 1'b0;
            sw_open_q <= 1'b1;
        end else if (clk_en) begin
            if (fuse_check_done & (fuse_parity_calc != fuse_parity_stored)) begin
                fuse_err_q <= 1'b1;
            end
            if (clr_hit) begin
                sw_open_q <= 1'b1;
            end
        end
    end
    assign fuse_parity_error = fuse_err_q;
    assign bus_switch_open = sw_open_q;
    assign clear_pulse = clr_hit;
    // ------------------------------------------------------------
    // response, sent in the next message
    // ------------------------------------------------------------
    logic pend_q, rsp_valid_q;
    logic [15:0] pend_word_q, rsp_word_q;
    wire logic [15:0] fmt_word = {assigned_address, NIBBLE_ZERO, wr_flag, ptr, echo};
    wire logic [15:0] id_word = {assigned_address, NIBBLE_ZERO, SILICON_VERSION[3:1], 1'b0,
        3'b000, fuse_err_q};
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            pend_q <= 1'b0;
            pend_word_q <= 16'h0000;
            rsp_valid_q <= 1'b0;
            rsp_word_q <= 16'h0000;
        end else if (clk_en) begin
            rsp_valid_q <= 1'b0;
            if (msg_start & pend_q) begin
                rsp_valid_q <= 1'b1;
                rsp_word_q <= pend_word_q;
                pend_q <= 1'b0;
            end
            if (clr_hit) begin
                pend_q <= 1'b0;
            end else if (fmt_rsp | id_rsp) begin
                pend_q <= 1'b1;
                pend_word_q <= fmt_rsp ? fmt_word : id_word;
            end
        end
    end
    assign rsp_valid = rsp_valid_q;
    assign rsp_word = rsp_word_q;
    // ------------------------------------------------------------
    // active format
    // ------------------------------------------------------------
    assign fmt_active.enhanced = enh;
    assign fmt_active.taps = enh ? taps_q : RST_TAPS;
    assign fmt_active.seed = enh ? seed_q : RST_SEED;
    assign fmt_active.bit_count = enh ? len_q : RST_LEN;
    assign crc_preload = fmt_active.seed;
    assign crc_poly = {1'b1, fmt_active.taps};
endmodule
`default_nettype wire

// *** bfcc_core_assertions.sv ***
// concurrent checks on the format control and clear command logic
`default_nettype none
module bfcc_core_assertions
    import bfcc_pkg::*;
(
    // watched ports
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic clk_en,
    input wire logic cmd_valid,
    input wire bfcc_pkg::bfcc_cmd_s cmd,
    input wire logic msg_start,
    input wire logic [3:0] assigned_address,
    input wire logic rsp_valid,
    input wire logic [15:0] rsp_word,
    input wire logic clear_pulse,
    input wire logic bus_switch_open,
    input wire bfcc_pkg::bfcc_fmt_s fmt_active
);
    localparam bfcc_fmt_s STD = {RST_TAPS, RST_SEED, RST_LEN, 1'b0};
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    wire logic hit = cmd.addr == assigned_address || cmd.addr == ADDR_GLOBAL;
    wire logic take = clk_en && cmd_valid && hit;
    wire logic fmt_go = take && cmd.cmd == CMD_FMT && cmd.kind == WORD_LONG;
    wire logic on_go = fmt_go && cmd.data == 8'hFF;
    wire logic off_go = clear_pulse || fmt_go && cmd.data == 8'hF0;
    clear_accept_a: assert property (clear_pulse == (take && cmd.cmd == CMD_CLEAR))
        else $error("clear pulse wrong");
    clear_reset_a: assert property (clear_pulse |=> bus_switch_open && fmt_active == STD)
        else $error("clear left state");
    clear_quiet_a: assert property (clear_pulse && !msg_start |=> !rsp_valid)
        else $error("clear answered");
    std_mode_a: assert property (!fmt_active.enhanced |-> fmt_active == STD)
        else $error("standard format wrong");
    enh_hold_a: assert property (fmt_active.enhanced && !clear_pulse ##1 fmt_active.enhanced
        |-> $stable(fmt_active)) else $error("format changed");
    enh_on_a: assert property ($rose(fmt_active.enhanced) |-> $past(on_go))
        else $error("enhanced without write");
    enh_off_a: assert property ($fell(fmt_active.enhanced) |-> $past(off_go))
        else $error("standard without write");
    rsp_form_a: assert property (rsp_valid |-> rsp_word[15:8] == {assigned_address, 4'h0})
        else $error("response head wrong");
    cover property (clear_pulse);
    cover property ($rose(fmt_active.enhanced));
    cover property (rsp_valid);
endmodule
bind bfcc_core bfcc_core_assertions i_bfcc_core_assertions (.*);
`default_nettype wire

// *** bfcc_core_tb.sv ***
// testbench for the format control and clear command logic
`default_nettype none
module bfcc_core_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import bfcc_pkg::*;
    localparam logic [15:0] NONE = 16'hFFFF;
    localparam bfcc_fmt_s STD = {RST_TAPS, RST_SEED, RST_LEN, 1'b0};
    logic clk_sys = 1'b0;
    logic arst_n = 1'b0;
    logic fchk = 1'b0;
    logic cmd_valid, msg_start, rsp_valid, clear_pulse, bus_switch_open, fuse_parity_error;
    bfcc_cmd_s cmd;
    bfcc_fmt_s fmt_active;
    logic [15:0] rsp_word;
    logic [3:0] crc_preload;
    logic [4:0] crc_poly;
    bfcc_word_e kinds[3] = '{WORD_LONG, WORD_SHORT8, WORD_SHORT10};
    int error_cnt = 0;
    int n_checks = 0;
    always #4 clk_sys = ~clk_sys;
    // version bit0 set on purpose; value arbitrary
    bfcc_core #(.SILICON_VERSION(4'h3)) i_bfcc_core (.clk_sys, .arst_n, .clk_en(1'b1),
        .cmd_valid, .cmd, .msg_start, .assigned_address(4'h5), .fuse_check_done(fchk),
        .fuse_parity_calc(1'b1), .fuse_parity_stored(1'b0), .rsp_valid, .rsp_word,
        .clear_pulse, .bus_switch_open, .fuse_parity_error, .fmt_active, .crc_preload,
        .crc_poly);
    bfcc_master i_bfcc_master (.clk_sys, .cmd_valid, .cmd, .msg_start, .rsp_valid, .rsp_word);
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // one command and its message; expected zero means not compared
    task automatic fc(input bfcc_word_e k, input logic [3:0] a, input logic [3:0] c,
        input logic [7:0] d, input logic [15:0] exp);
        logic got;
        logic [15:0] w;
        i_bfcc_master.send('{k, d, a, c});
        i_bfcc_master.msg(got, w);
        if (exp !== 16'h0000) begin
            chk(got ? w : NONE, exp);
        end
    endtask
    task automatic fw(input logic [7:0] d, input logic [15:0] exp);
        fc(WORD_LONG, 4'h5, CMD_FMT, d, exp);
    endtask
    task automatic finish_test();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        #50us;
        error_cnt++;
        finish_test();
    end
    initial begin
        repeat (12) @(posedge clk_sys);
        #1 arst_n = 1'b1;
        chk({3'h0, fmt_active}, {3'h0, STD});
        chk({11'h0, crc_poly}, 16'h0011);
        chk({12'h0, crc_preload}, 16'h000A);
        chk({15'h0, bus_switch_open}, 16'h0001);
        @(posedge clk_sys) #1 fchk = 1'b1;
        @(posedge clk_sys) #1 fchk = 1'b0;
        chk({15'h0, fuse_parity_error}, 16'h0001);
        fc(WORD_LONG, 4'h5, CMD_ID, 8'h00, 16'h5021);
        fc(WORD_LONG, 4'h0, CMD_ID, 8'h00, NONE);
        fc(WORD_SHORT8, 4'h5, CMD_ID, 8'h00, NONE);
        $display("test identity done");
        fw(8'h83, 16'h5083);
        fw(8'h03, 16'h5003);
        fw(8'h9F, 16'h5090);
        fw(8'hDA, 16'h50DA);
        fw(8'hD3, 16'h0000);
        fw(8'h50, 16'h505A);
        fc(WORD_LONG, 4'h0, CMD_FMT, 8'hA4, NONE);
        fw(8'h20, 16'h5024);
        fw(8'hF7, 16'h0000);
        fw(8'h70, 16'h5070);
        chk({3'h0, fmt_active}, {3'h0, STD});
        fw(8'hFF, 16'h50FF);
        chk({3'h0, fmt_active}, {3'h0, 4'h3, 4'h4, LEN_10, 1'b1});
        chk({11'h0, crc_poly}, 16'h0013);
        fw(8'h85, 16'h0000);
        fw(8'h00, 16'h5003);
        fw(8'hF8, 16'h0000);
        fc(WORD_LONG, 4'h3, CMD_FMT, 8'hF0, NONE);
        fc(WORD_SHORT10, 4'h5, CMD_FMT, 8'hF0, NONE);
        fc(WORD_LONG, 4'h3, CMD_CLEAR, 8'h00, NONE);
        chk({15'h0, fmt_active.enhanced}, 16'h0001);
        fw(8'hF0, 16'h50F0);
        chk({3'h0, fmt_active}, {3'h0, STD});
        foreach (kinds[i]) begin
            fw(8'hFF, 16'h0000);
            fc(kinds[i], (i == 1) ? 4'h0 : 4'h5, CMD_CLEAR, 8'h00, NONE);
            chk({3'h0, fmt_active}, {3'h0, STD});
        end
        fw(8'h00, 16'h5001);
        $display("test format and clear done");
        finish_test();
    end
endmodule
`default_nettype wire

// *** bfcc_master.sv ***
// bus master model that sends command words and opens messages
`default_nettype none
module bfcc_master
    import bfcc_pkg::*;
(
    // clock
    input wire logic clk_sys,
    // commands and message starts
    output logic cmd_valid,
    output bfcc_pkg::bfcc_cmd_s cmd,
    output logic msg_start,
    // responses
    input wire logic rsp_valid,
    input wire logic [15:0] rsp_word
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        cmd_valid = 1'b0;
        msg_start = 1'b0;
        cmd = '0;
    end
    task automatic send(input bfcc_cmd_s c);
        @(posedge clk_sys) #1;
        cmd = c;
        cmd_valid = 1'b1;
        @(posedge clk_sys) #1;
        cmd_valid = 1'b0;
        cmd = ~c;
    endtask
    // opens the next message and collects any response in it
    task automatic msg(output logic got, output logic [15:0] w);
        @(posedge clk_sys) #1;
        msg_start = 1'b1;
        @(posedge clk_sys) #1;
        msg_start = 1'b0;
        got = 1'b0;
        w = 16'h0000;
        // sample just after each edge so the one-cycle response is seen settled
        repeat (3) begin
            if (rsp_valid) begin
                got = 1'b1;
                w = rsp_word;
            end
            @(posedge clk_sys) #1;
        end
    endtask
endmodule
`default_nettype wire

// *** bfcc_pkg.sv ***
// package for the bus format control and clear command logic
`default_nettype none
package bfcc_pkg;
    // ------------------------------------------------------------
    // command codes and word kinds
    // ------------------------------------------------------------
    localparam logic [3:0] CMD_CLEAR = 4'h7;
    localparam logic [3:0] CMD_ID = 4'h4;
    localparam logic [3:0] CMD_FMT = 4'hA;
    localparam logic [3:0] ADDR_GLOBAL = 4'h0;
    typedef enum logic [2:0] {
        WORD_LONG = 3'b001,
        WORD_SHORT8 = 3'b010,
        WORD_SHORT10 = 3'b100
    } bfcc_word_e;
    // ------------------------------------------------------------
    // format register locations and reset values
    // ------------------------------------------------------------
    localparam logic [2:0] LOC_TAPS = 3'h0;
    localparam logic [2:0] LOC_SEED = 3'h2;
    localparam logic [2:0] LOC_LEN = 3'h5;
    localparam logic [2:0] LOC_SEL = 3'h7;
    localparam logic [3:0] RST_TAPS = 4'h1;
    localparam logic [3:0] RST_SEED = 4'hA;
    localparam logic [3:0] RST_LEN = 4'h8;
    localparam logic [3:0] RST_SEL = 4'h0;
    localparam logic [3:0] LEN_8 = 4'h8;
    localparam logic [3:0] LEN_10 = 4'hA;
    localparam logic [3:0] SEL_ON = 4'hF;
    localparam logic [3:0] SEL_OFF = 4'h0;
    localparam logic [3:0] NIBBLE_ZERO = 4'h0;
    // ------------------------------------------------------------
    // data byte field positions
    // ------------------------------------------------------------
    localparam int FB_WR = 7;
    localparam int FB_PTR_HI = 6;
    localparam int FB_PTR_LO = 4;
    localparam int FB_DAT_HI = 3;
    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        bfcc_word_e kind;
        logic [7:0] data;
        logic [3:0] addr;
        logic [3:0] cmd;
    } bfcc_cmd_s;
    typedef struct packed {
        logic [3:0] taps;
        logic [3:0] seed;
        logic [3:0] bit_count;
        logic enhanced;
    } bfcc_fmt_s;
endpackage
`default_nettype wire
